// ==== design/uem_cfg.svh ====
// offsets, field positions, reset values of the error mask block
`ifndef UEM_CFG_SVH
`define UEM_CFG_SVH

`define UEM_MASK_OFF   12'h108
`define UEM_IST_OFF    12'h180
`define UEM_IMSK_OFF   12'h184

`define UEM_MASK_IMPL  32'h003f_f031
`define UEM_MASK_RST   32'h0000_0000
`define UEM_IST_RST    32'h0000_0000
`define UEM_IMSK_RST   32'h0000_0000
`define UEM_DAT_ZERO   32'h0000_0000

`define UEM_B_TRAIN    0
`define UEM_B_DLP      4
`define UEM_B_SDOWN    5
`define UEM_B_POISON   12
`define UEM_B_FCP      13
`define UEM_B_CTO      14
`define UEM_B_CABORT   15
`define UEM_B_UNXCPL   16
`define UEM_B_RXOVF    17
`define UEM_B_MALF     18
`define UEM_B_ECRC     19
`define UEM_B_UNSUP    20
`define UEM_B_ACS      21

`endif

// ==== design/uem_pkg.sv ====
// types shared by the error mask block
package uem_pkg;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [11:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } uem_wb_req_t;

    typedef struct packed {
        logic [31:0] log;
        logic [31:0] msg;
    } uem_rpt_t;

endpackage : uem_pkg

// ==== design/uem_gate.sv ====
// per-error gate: passes unmasked error events to log and message paths
`timescale 1ns/1ns
module uem_gate #(
    parameter int W = 32
) (
    // clock and resets
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         clr_i,
    // events and effective mask
    input  wire logic [W-1:0] evt_i,
    input  wire logic [W-1:0] mask_i,
    // gated requests
    output logic      [W-1:0] log_o,
    output logic      [W-1:0] msg_o
);

    wire [W-1:0] pass = evt_i & ~mask_i;

    // log and message share the same gate, so they never disagree
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            log_o <= '0;
            msg_o <= '0;
        end else begin
            log_o <= pass;
            msg_o <= pass;
        end
    end

endmodule : uem_gate

// ==== design/uem_top.sv ====
// uncorrectable error mask register with wishbone slave and gating
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ns
`include "uem_cfg.svh"

// Behaviour
// - mask bit 0 blocks training error reports
// - mask bit 4 blocks data link protocol
// - mask bit 5 surprise down, downstream only
// - mask bit 12 blocks poisoned tlp reports
// - mask bit 13 blocks flow control errors
// - mask bit 14 blocks completion timeout reports
// - mask bit 15 blocks completer abort reports
// - mask bit 16 blocks unexpected completion reports
// - mask bit 17 blocks receiver overflow reports
// - mask bit 18 blocks malformed tlp reports
// - mask bit 19 blocks end-to-end crc reports
// - mask bit 20 blocks unsupported request reports
module uem_top (
    // clock and resets
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                hot_rst_i,
    // port role
    input  wire logic                downstream_i,
    // wishbone slave
    input  wire uem_pkg::uem_wb_req_t wb_i,
    output logic                     wb_ack_o,
    output logic [31:0]              wb_dat_o,
    // error events, one pulse per detected error
    input  wire logic [31:0]         err_evt_i,
    // gated header log and message requests
    output uem_pkg::uem_rpt_t        rpt_o,
    output logic [31:0]              mask_o,
    // interrupt
    output logic                     irq_o
);
    import uem_pkg::*;

    logic [31:0] mask_q;
    logic [31:0] ist_q;
    logic [31:0] imsk_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    // one driver for the whole report struct
    logic [31:0] log_req;
    logic [31:0] msg_req;

    // bus decode
    wire        req      = wb_i.cyc & wb_i.stb;
    wire        next_ack = req & ~ack_q;
    wire        hit_mask = (wb_i.adr[11:2] == 10'(`UEM_MASK_OFF >> 2));
    wire        hit_ist  = (wb_i.adr[11:2] == 10'(`UEM_IST_OFF >> 2));
    wire        hit_imsk = (wb_i.adr[11:2] == 10'(`UEM_IMSK_OFF >> 2));
    // a write commits at the edge where the master sees ack
    wire        wr_en    = req & wb_i.we & ack_q;
    wire        wr_mask  = wr_en & hit_mask;
    wire        wr_ist   = wr_en & hit_ist;
    wire        wr_imsk  = wr_en & hit_imsk;
    wire [31:0] byte_en  = {{8{wb_i.sel[3]}}, {8{wb_i.sel[2]}},
                            {8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};
    wire [31:0] wbits    = wb_i.dat & byte_en;

    // unmapped addresses answer with zero data
    wire [31:0] next_rdat = hit_mask ? mask_q :
                            hit_ist  ? ist_q  :
                            hit_imsk ? imsk_q : `UEM_DAT_ZERO;

    // reserved bits never stored, so they read as zero
    wire [31:0] next_mask = ((mask_q & ~byte_en) | wbits)
                            & `UEM_MASK_IMPL;

    // surprise down exists only on downstream ports
    wire [31:0] port_ok   = downstream_i ? `UEM_MASK_IMPL :
                            (`UEM_MASK_IMPL & ~(32'h1 << `UEM_B_SDOWN));
    wire [31:0] evt_ok    = err_evt_i & port_ok;
    wire [31:0] eff_mask  = mask_q & port_ok;

    // set wins over a write-one clear in the same cycle
    wire [31:0] next_ist  = (ist_q & ~(wr_ist ? wbits : 32'h0)) | evt_ok;
    wire [31:0] next_imsk = wr_imsk ? (wbits & `UEM_MASK_IMPL) : imsk_q;

    // sticky: hot reset leaves the mask alone
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= `UEM_MASK_RST;
        end else if (wr_mask) begin
            mask_q <= next_mask;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || hot_rst_i) begin
            ist_q  <= `UEM_IST_RST;
            imsk_q <= `UEM_IMSK_RST;
        end else begin
            ist_q  <= next_ist;
            imsk_q <= next_imsk;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= `UEM_DAT_ZERO;
        end else begin
            ack_q  <= next_ack;
            rdat_q <= next_rdat;
        end
    end

    // every masked bit drops both header log and message
    uem_gate #(
        .W (32)
    ) u_gate (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .clr_i  (hot_rst_i),
        .evt_i  (evt_ok),
        .mask_i (eff_mask),
        .log_o  (log_req),
        .msg_o  (msg_req)
    );

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign mask_o   = mask_q;
    assign irq_o    = |(ist_q & imsk_q);
    assign rpt_o    = '{log: log_req, msg: msg_req};

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || hot_rst_i);

    a_train_masked: assert property (
        mask_q[`UEM_B_TRAIN] && err_evt_i[`UEM_B_TRAIN]
        |=> !rpt_o.log[`UEM_B_TRAIN] && !rpt_o.msg[`UEM_B_TRAIN])
        else $error("masked training error was reported");

    a_train_passes: assert property (
        !mask_q[`UEM_B_TRAIN] && err_evt_i[`UEM_B_TRAIN]
        |=> rpt_o.log[`UEM_B_TRAIN] && rpt_o.msg[`UEM_B_TRAIN])
        else $error("unmasked training error was dropped");

    a_dlp_masked: assert property (
        mask_q[`UEM_B_DLP] && err_evt_i[`UEM_B_DLP]
        |=> !rpt_o.log[`UEM_B_DLP] && !rpt_o.msg[`UEM_B_DLP])
        else $error("masked data link protocol error was reported");

    a_sdown_masked: assert property (
        downstream_i && mask_q[`UEM_B_SDOWN] && err_evt_i[`UEM_B_SDOWN]
        |=> !rpt_o.log[`UEM_B_SDOWN] && !rpt_o.msg[`UEM_B_SDOWN])
        else $error("masked surprise down was reported");

    a_sdown_upstream: assert property (
        !downstream_i ##1 1'b1 |-> !rpt_o.msg[`UEM_B_SDOWN])
        else $error("surprise down reported on an upstream port");

    a_sdown_passes: assert property (
        downstream_i && !mask_q[`UEM_B_SDOWN] && err_evt_i[`UEM_B_SDOWN]
        |=> rpt_o.msg[`UEM_B_SDOWN])
        else $error("unmasked surprise down was dropped");

    a_poison_masked: assert property (
        mask_q[`UEM_B_POISON] && err_evt_i[`UEM_B_POISON]
        |=> !rpt_o.log[`UEM_B_POISON] && !rpt_o.msg[`UEM_B_POISON])
        else $error("masked poisoned tlp was reported");

    a_fcp_masked: assert property (
        mask_q[`UEM_B_FCP] && err_evt_i[`UEM_B_FCP]
        |=> !rpt_o.log[`UEM_B_FCP] && !rpt_o.msg[`UEM_B_FCP])
        else $error("masked flow control error was reported");

    a_cto_masked: assert property (
        mask_q[`UEM_B_CTO] && err_evt_i[`UEM_B_CTO]
        |=> !rpt_o.log[`UEM_B_CTO] && !rpt_o.msg[`UEM_B_CTO])
        else $error("masked completion timeout was reported");

    a_cabort_masked: assert property (
        mask_q[`UEM_B_CABORT] && err_evt_i[`UEM_B_CABORT]
        |=> !rpt_o.log[`UEM_B_CABORT] && !rpt_o.msg[`UEM_B_CABORT])
        else $error("masked completer abort was reported");

    a_unxcpl_masked: assert property (
        mask_q[`UEM_B_UNXCPL] && err_evt_i[`UEM_B_UNXCPL]
        |=> !rpt_o.log[`UEM_B_UNXCPL] && !rpt_o.msg[`UEM_B_UNXCPL])
        else $error("masked unexpected completion was reported");

    a_rxovf_masked: assert property (
        mask_q[`UEM_B_RXOVF] && err_evt_i[`UEM_B_RXOVF]
        |=> !rpt_o.log[`UEM_B_RXOVF] && !rpt_o.msg[`UEM_B_RXOVF])
        else $error("masked receiver overflow was reported");

    a_malf_masked: assert property (
        mask_q[`UEM_B_MALF] && err_evt_i[`UEM_B_MALF]
        |=> !rpt_o.log[`UEM_B_MALF] && !rpt_o.msg[`UEM_B_MALF])
        else $error("masked malformed tlp was reported");

    a_ecrc_masked: assert property (
        mask_q[`UEM_B_ECRC] && err_evt_i[`UEM_B_ECRC]
        |=> !rpt_o.log[`UEM_B_ECRC] && !rpt_o.msg[`UEM_B_ECRC])
        else $error("masked ecrc error was reported");

    a_unsup_masked: assert property (
        mask_q[`UEM_B_UNSUP] && err_evt_i[`UEM_B_UNSUP]
        |=> !rpt_o.log[`UEM_B_UNSUP] && !rpt_o.msg[`UEM_B_UNSUP])
        else $error("masked unsupported request was reported");

    a_acs_masked: assert property (
        mask_q[`UEM_B_ACS] && err_evt_i[`UEM_B_ACS]
        |=> !rpt_o.log[`UEM_B_ACS] && !rpt_o.msg[`UEM_B_ACS])
        else $error("masked acs violation was reported");

    a_acs_write: assert property (
        wr_mask && wb_i.sel[2]
        |=> mask_q[`UEM_B_ACS] == $past(wb_i.dat[`UEM_B_ACS]))
        else $error("acs mask bit did not take the written value");

    // pass-through side: a clear mask bit must let the event out
    a_poison_passes: assert property (
        !mask_q[`UEM_B_POISON] && err_evt_i[`UEM_B_POISON]
        |=> rpt_o.log[`UEM_B_POISON] && rpt_o.msg[`UEM_B_POISON])
        else $error("unmasked poisoned tlp was dropped");

    a_fcp_passes: assert property (
        !mask_q[`UEM_B_FCP] && err_evt_i[`UEM_B_FCP]
        |=> rpt_o.log[`UEM_B_FCP] && rpt_o.msg[`UEM_B_FCP])
        else $error("unmasked flow control error was dropped");

    a_cto_passes: assert property (
        !mask_q[`UEM_B_CTO] && err_evt_i[`UEM_B_CTO]
        |=> rpt_o.log[`UEM_B_CTO] && rpt_o.msg[`UEM_B_CTO])
        else $error("unmasked completion timeout was dropped");

    a_malf_passes: assert property (
        !mask_q[`UEM_B_MALF] && err_evt_i[`UEM_B_MALF]
        |=> rpt_o.log[`UEM_B_MALF] && rpt_o.msg[`UEM_B_MALF])
        else $error("unmasked malformed tlp was dropped");

    a_ecrc_passes: assert property (
        !mask_q[`UEM_B_ECRC] && err_evt_i[`UEM_B_ECRC]
        |=> rpt_o.log[`UEM_B_ECRC] && rpt_o.msg[`UEM_B_ECRC])
        else $error("unmasked ecrc error was dropped");

    a_unsup_passes: assert property (
        !mask_q[`UEM_B_UNSUP] && err_evt_i[`UEM_B_UNSUP]
        |=> rpt_o.log[`UEM_B_UNSUP] && rpt_o.msg[`UEM_B_UNSUP])
        else $error("unmasked unsupported request was dropped");

    a_acs_passes: assert property (
        !mask_q[`UEM_B_ACS] && err_evt_i[`UEM_B_ACS]
        |=> rpt_o.log[`UEM_B_ACS] && rpt_o.msg[`UEM_B_ACS])
        else $error("unmasked acs violation was dropped");

    a_mask_read: assert property (
        wb_ack_o && $past(hit_mask && !wb_i.we) |-> wb_dat_o == mask_q)
        else $error("mask read returned a stale value");

    a_mask_hold: assert property (
        !wr_mask |=> $stable(mask_q))
        else $error("mask changed without a bus write");

    a_rsvd_write: assert property (
        wr_mask |=> (mask_q & ~`UEM_MASK_IMPL) == 32'h0)
        else $error("reserved mask bits were stored");

    a_mask_sticky: assert property (
        @(posedge clk_i) disable iff (rst_i)
        hot_rst_i && !wr_mask |=> $stable(mask_q))
        else $error("mask changed across a hot reset");

    a_mask_fund_rst: assert property (
        @(posedge clk_i) disable iff (1'b0)
        rst_i |=> mask_q == `UEM_MASK_RST)
        else $error("mask not cleared by fundamental reset");

    a_rsvd_zero: assert property (
        wb_ack_o && $past(hit_mask) |-> (wb_dat_o & ~`UEM_MASK_IMPL) == 0)
        else $error("reserved mask bits read nonzero");

    a_ack_one: assert property (
        req && !ack_q |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle after request");

    a_set_wins: assert property (
        evt_ok[`UEM_B_TRAIN] |=> ist_q[`UEM_B_TRAIN])
        else $error("error event lost from interrupt status");

    // hot reset must wipe the reports and irq state (ist, imsk) but not the sticky mask
    a_hot_clears: assert property (
        @(posedge clk_i) disable iff (rst_i)
        hot_rst_i |=> rpt_o == '0 && ist_q == '0 && imsk_q == '0)
        else $error("hot reset left irq state or reports set");

    c_masked_evt: cover property (
        mask_q[`UEM_B_CTO] && err_evt_i[`UEM_B_CTO]);
    c_unmasked_evt: cover property (
        !mask_q[`UEM_B_MALF] && err_evt_i[`UEM_B_MALF] ##1 irq_o);
    c_mask_write: cover property (wr_mask ##1 mask_q != 32'h0);
    c_hot_keep: cover property (
        @(posedge clk_i) disable iff (rst_i)
        hot_rst_i && mask_q != 32'h0);

endmodule : uem_top

// ==== verif/uem_rc_model.sv ====
// root complex stand-in that counts the error messages it receives
`timescale 1ns/1ns
module uem_rc_model (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // error messages from the port
    input  wire logic [31:0] msg_i,
    output int               n_msg_o
);
    // one message per set bit per cycle, no backpressure on this path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            n_msg_o <= 0;
        end else begin
            n_msg_o <= n_msg_o + $countones(msg_i);
        end
    end
endmodule : uem_rc_model

// ==== verif/uncorrectable_error_mask_bench.sv ====
// self-checking bench for the uncorrectable error mask register
`timescale 1ns/1ns
`include "uem_cfg.svh"
module uncorrectable_error_mask_bench;
    import uem_pkg::*;
    typedef struct packed {
        logic [31:0] evt;
        logic [31:0] msk;
        logic        dn;
        logic [31:0] exp;
    } uem_row_t;
    logic        clk_i;
    logic        rst_i;
    logic        hot_rst_i;
    logic        downstream_i;
    uem_wb_req_t wb_i;
    logic        wb_ack_o;
    logic [31:0] wb_dat_o;
    logic [31:0] err_evt_i;
    uem_rpt_t    rpt_o;
    logic [31:0] mask_o;
    logic        irq_o;
    logic [31:0] q;
    int          n_msg;
    int          n_exp;
    int          n_fail;
    int          checked;
    // every implemented bit is seen both masked and unmasked
    uem_row_t    rows [7] = '{
        '{32'h003f_f031, 32'h0000_0000, 1'b1, 32'h003f_f031},
        '{32'h003f_f031, 32'h003f_f031, 1'b1, 32'h0000_0000},
        '{32'h003f_f031, 32'h0005_5010, 1'b1, 32'h003a_a021},
        '{32'h003f_f031, 32'h002a_a021, 1'b1, 32'h0015_5010},
        '{32'hffc0_0fce, 32'h0000_0000, 1'b1, 32'h0000_0000},
        '{32'h0000_0020, 32'h0000_0000, 1'b0, 32'h0000_0000},
        '{32'h0000_0020, 32'h0000_0020, 1'b1, 32'h0000_0000}
    };

    uem_top dut (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .hot_rst_i    (hot_rst_i),
        .downstream_i (downstream_i),
        .wb_i         (wb_i),
        .wb_ack_o     (wb_ack_o),
        .wb_dat_o     (wb_dat_o),
        .err_evt_i    (err_evt_i),
        .rpt_o        (rpt_o),
        .mask_o       (mask_o),
        .irq_o        (irq_o)
    );

    uem_rc_model rc (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .msg_i   (rpt_o.msg),
        .n_msg_o (n_msg)
    );

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic tally_and_finish();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask : chk

    // classic single cycle; bounded wait so a dead slave cannot hang us
    task automatic wb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int k;
        k = 0;
        wb_i <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        r = wb_dat_o;
        wb_i <= '0;
        if (wb_ack_o !== 1'b1) begin
            n_fail++;
            tally_and_finish();
        end else begin
            @(posedge clk_i);
        end
    endtask : wb

    task automatic pulse(input logic [31:0] e, input logic [31:0] x);
        err_evt_i <= e;
        @(posedge clk_i);
        err_evt_i <= '0;
        #1;
        chk(rpt_o.log, x);
        chk(rpt_o.msg, x);
        @(posedge clk_i);
    endtask : pulse

    initial begin
        rst_i = 1'b1;
        hot_rst_i = 1'b0;
        downstream_i = 1'b1;
        err_evt_i = '0;
        wb_i = '0;
        n_fail = 0;
        checked = 0;
        n_exp = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(mask_o, `UEM_MASK_RST);
        foreach (rows[i]) begin
            downstream_i <= rows[i].dn;
            wb(1'b1, `UEM_MASK_OFF, rows[i].msk, q);
            chk(mask_o, rows[i].msk);
            pulse(rows[i].evt, rows[i].exp);
            n_exp += $countones(rows[i].exp);
        end
        #1;
        chk(32'(n_msg), 32'(n_exp));
        @(posedge clk_i);
        // reserved bits must not stick
        wb(1'b1, `UEM_MASK_OFF, 32'hffff_ffff, q);
        wb(1'b0, `UEM_MASK_OFF, 32'h0000_0000, q);
        chk(q, `UEM_MASK_IMPL);
        wb(1'b0, 12'h10c, 32'h0000_0000, q);
        chk(q, `UEM_DAT_ZERO);
        // status bits were left set by the rows above
        chk({31'h0, irq_o}, 32'h0000_0000);
        wb(1'b1, `UEM_IMSK_OFF, 32'h0000_0001, q);
        chk({31'h0, irq_o}, 32'h0000_0001);
        wb(1'b1, `UEM_IST_OFF, `UEM_MASK_IMPL, q);
        wb(1'b0, `UEM_IST_OFF, 32'h0000_0000, q);
        chk(q, `UEM_IST_RST);
        chk({31'h0, irq_o}, 32'h0000_0000);
        // event lands on the edge that commits the clear: set must win
        fork
            wb(1'b1, `UEM_IST_OFF, 32'h0000_0001, q);
            begin
                @(posedge clk_i);
                err_evt_i <= 32'h0000_0001;
                @(posedge clk_i);
                err_evt_i <= '0;
            end
        join
        wb(1'b0, `UEM_IST_OFF, 32'h0000_0000, q);
        chk(q, 32'h0000_0001);
        chk({31'h0, irq_o}, 32'h0000_0001);
        hot_rst_i <= 1'b1;
        @(posedge clk_i);
        hot_rst_i <= 1'b0;
        @(posedge clk_i);
        chk(mask_o, `UEM_MASK_IMPL);
        // hot reset clears the irq side, not the mask
        wb(1'b0, `UEM_IST_OFF, 32'h0000_0000, q);
        chk(q, `UEM_IST_RST);
        wb(1'b0, `UEM_IMSK_OFF, 32'h0000_0000, q);
        chk(q, `UEM_IMSK_RST);
        chk({31'h0, irq_o}, 32'h0000_0000);
        wb(1'b0, `UEM_MASK_OFF, 32'h0000_0000, q);
        chk(q, `UEM_MASK_IMPL);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(mask_o, `UEM_MASK_RST);
        tally_and_finish();
    end
endmodule : uncorrectable_error_mask_bench
